// >>> shared/rtc_pkg.sv
// Constants shared by the seconds and nanoseconds time counter and its time base
package rtc_pkg;

    // Word widths
    localparam int SEC_W = 32;
    localparam int FRAC_W = 32;

    // Lowest implemented bit of the fraction word: 2**8 ns = 256 ns resolution
    localparam int FRAC_LSB = 8;

    // Time base
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_NS = 1 << FRAC_LSB;
    localparam int PHASE_W = 16;

    // Last nanosecond value inside one second
    localparam logic [31:0] NS_LAST_IN_SECOND = 32'h3B9AC9FF;

    // Terminal count: largest implementable value not above the last nanosecond
    localparam logic [31:0] FRAC_TERMINAL = (NS_LAST_IN_SECOND >> FRAC_LSB) << FRAC_LSB;

    // Values loaded by rst
    localparam logic [31:0] SEC_RESET = 32'h00000000;
    localparam logic [31:0] FRAC_RESET = 32'h00000000;
    localparam logic [31:0] RDATA_RESET = 32'h00000000;

    // Special register select
    localparam logic SEL_FRACTION = 1'b0;
    localparam logic SEL_SECONDS = 1'b1;

    // First value software loads into the fraction word when setting the time
    localparam logic [31:0] INIT_CLEAR_LOAD = 32'h0000FFFF;

endpackage : rtc_pkg

// >>> rtl/time_base_tick.sv
// Fractional divider producing one enable pulse per resolution step of the fraction word
`timescale 1ns/1ps
module time_base_tick #(
    parameter int CLK_PERIOD_NS = rtc_pkg::CLK_PERIOD_NS,
    parameter int TICK_NS = rtc_pkg::TICK_NS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // One-cycle pulse every TICK_NS on average
    output logic tick
);

    localparam logic [rtc_pkg::PHASE_W-1:0] STEP = rtc_pkg::PHASE_W'(CLK_PERIOD_NS);
    localparam logic [rtc_pkg::PHASE_W-1:0] LIMIT = rtc_pkg::PHASE_W'(TICK_NS);

    logic [rtc_pkg::PHASE_W-1:0] phase_r;
    logic [rtc_pkg::PHASE_W-1:0] phase_nxt;
    logic tick_r;
    logic tick_nxt;
    logic [rtc_pkg::PHASE_W-1:0] sum;

    // Period does not divide the step evenly, so the remainder is carried over;
    // individual steps jitter by one clock but long-run rate is exact.
    always_comb begin
        sum = phase_r + STEP;
        if (sum >= LIMIT) begin
            phase_nxt = sum - LIMIT;
            tick_nxt = 1'b1;
        end else begin
            phase_nxt = sum;
            tick_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            phase_r <= '0;
            tick_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;

endmodule : time_base_tick

// >>> rtl/seconds_nanoseconds_time_counter.sv
// Two-word time-of-day counter: seconds word and nanosecond fraction word
`timescale 1ns/1ps
// Operation
// - Upper word counts seconds from software epoch; lower word counts nanoseconds.
// - Implemented fraction bits count upward as a plain binary counter.
// - Fraction word advances in 256 ns steps; lower bits absent.
// - Fraction reaches terminal nearest below 999,999,999, then returns to zero.
// - Uninitialised fraction word still reaches zero within four seconds.
// - Fraction loaded above 999,999,999 returns to zero within four seconds.
// - Reading fraction leaves counting undisturbed; unimplemented bits read zero.
// - Fraction write replaces implemented bits only; other source bits dropped.
// - Seconds word increments in the same update as the fraction wrap.
// - Seconds word is a full 32-bit counter that always runs.
// - Seconds word rolls from all ones to all zeros.
// - Seconds read is harmless; seconds write replaces all 32 bits.
// - Both words count from rst, which loads zero into each.
// - Writes need privilege; unprivileged write raises program interrupt, no change.
// - Reads are allowed unprivileged and never change the counter.
module seconds_nanoseconds_time_counter #(
    parameter int FRAC_LSB = rtc_pkg::FRAC_LSB,
    parameter int CLK_PERIOD_NS = rtc_pkg::CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Special register move request from the core
    input wire logic spr_valid,
    input wire logic spr_write,
    input wire logic spr_sel,
    input wire logic [31:0] spr_wdata,
    input wire logic spr_privileged,
    // Answer to the core
    output logic [31:0] spr_rdata,
    output logic spr_done,
    output logic program_interrupt,
    // Live counter contents
    output logic [31:0] seconds_count_word,
    output logic [31:0] fraction_ns_word
);

    localparam logic [31:0] FRAC_UNIT = 32'h00000001 << FRAC_LSB;
    localparam logic [31:0] TERMINAL = (rtc_pkg::NS_LAST_IN_SECOND >> FRAC_LSB) << FRAC_LSB;

    // Keeps only implemented fraction bit positions
    function automatic logic [31:0] frac_implemented(input logic [31:0] value);
        logic [31:0] mask;
        mask = ~(FRAC_UNIT - 32'h00000001);
        return value & mask;
    endfunction : frac_implemented

    // Counter state
    logic [31:0] sec_r;
    logic [31:0] sec_nxt;
    logic [31:0] frac_r;
    logic [31:0] frac_nxt;

    // Answer state
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic done_r;
    logic done_nxt;
    logic irq_r;
    logic irq_nxt;

    // Decoded request and counting terms
    logic tick;
    logic wr_allowed;
    logic wr_frac;
    logic wr_sec;
    logic rd_req;
    logic at_or_past_terminal;
    logic wrap;
    logic carry;
    logic [31:0] frac_count;
    logic [31:0] sec_count;

    // Shared time base; a decrementer would hang off the same pulse
    time_base_tick #(
        .CLK_PERIOD_NS(CLK_PERIOD_NS),
        .TICK_NS(1 << FRAC_LSB)
    ) u_tick (
        .clk(clk),
        .rst(rst),
        .tick(tick)
    );

    // Request decode
    always_comb begin
        wr_allowed = spr_valid && spr_write && spr_privileged;
        wr_frac = wr_allowed && (spr_sel == rtc_pkg::SEL_FRACTION);
        wr_sec = wr_allowed && (spr_sel == rtc_pkg::SEL_SECONDS);
        rd_req = spr_valid && !spr_write;
    end

    // Counting path
    always_comb begin
        // Anything at or above terminal wraps on the next step, so an out-of-range
        // load is cleared on the next tick, within 300 ns, rather than running up to the 2**32 rollover.
        at_or_past_terminal = (frac_r >= TERMINAL);
        wrap = tick && at_or_past_terminal;
        if (wrap) begin
            frac_count = 32'h00000000;
        end else if (tick) begin
            frac_count = frac_implemented(frac_r + FRAC_UNIT);
        end else begin
            frac_count = frac_r;
        end
        // A fraction write replaces the update, so its carry goes with it
        carry = wrap && !wr_frac;
        if (carry) begin
            sec_count = sec_r + 32'h00000001;
        end else begin
            sec_count = sec_r;
        end
    end

    // Write merge: software value wins over the same cycle's count
    always_comb begin
        if (wr_frac) begin
            frac_nxt = frac_implemented(spr_wdata);
        end else begin
            frac_nxt = frac_count;
        end
        if (wr_sec) begin
            sec_nxt = spr_wdata;
        end else begin
            sec_nxt = sec_count;
        end
    end

    // Counter registers; rst gives a known start, counting begins at once
    always_ff @(posedge clk) begin
        if (rst) begin
            sec_r <= rtc_pkg::SEC_RESET;
            frac_r <= rtc_pkg::FRAC_RESET;
        end else begin
            sec_r <= sec_nxt;
            frac_r <= frac_nxt;
        end
    end

    // Answer path
    always_comb begin
        rdata_nxt = rdata_r;
        if (rd_req) begin
            if (spr_sel == rtc_pkg::SEL_SECONDS) begin
                rdata_nxt = sec_r;
            end else begin
                rdata_nxt = frac_implemented(frac_r);
            end
        end
        done_nxt = spr_valid;
        irq_nxt = spr_valid && spr_write && !spr_privileged;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= rtc_pkg::RDATA_RESET;
            done_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            done_r <= done_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign spr_rdata = rdata_r;
    assign spr_done = done_r;
    assign program_interrupt = irq_r;
    assign seconds_count_word = sec_r;
    assign fraction_ns_word = frac_r;

endmodule : seconds_nanoseconds_time_counter

// >>> bench/rtc_props.sv
// Port checker for the two-word time counter
`timescale 1ns/1ps
module rtc_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Request
    input wire logic spr_valid,
    input wire logic spr_write,
    input wire logic spr_sel,
    input wire logic [31:0] spr_wdata,
    input wire logic spr_privileged,
    // Answer and counter
    input wire logic [31:0] spr_rdata,
    input wire logic spr_done,
    input wire logic program_interrupt,
    input wire logic [31:0] seconds_count_word,
    input wire logic [31:0] fraction_ns_word
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    wire logic bad = spr_valid & spr_write & ~spr_privileged;
    wire logic ws = spr_valid & spr_write & spr_privileged & spr_sel;
    wire logic wf = spr_valid & spr_write & spr_privileged & ~spr_sel;
    wire logic rd = spr_valid & ~spr_write;
    done_answer_a: assert property (spr_valid |=> spr_done) else $error("no done");
    irq_cause_a: assert property (bad |=> program_interrupt) else $error("no irq");
    irq_only_a: assert property (!bad |=> !program_interrupt) else $error("stray irq");
    low_bits_a: assert property (fraction_ns_word[7:0] == 8'h00) else $error("low bits");
    sec_load_a: assert property (ws |=> seconds_count_word == $past(spr_wdata))
        else $error("seconds load");
    frac_load_a: assert property (wf |=>
        fraction_ns_word == {$past(spr_wdata[31:8]), 8'h00}) else $error("fraction load");
    // A fraction write in a wrap cycle must swallow that cycle's carry
    carry_drop_a: assert property (wf |=> $stable(seconds_count_word))
        else $error("carry kept");
    rd_sec_a: assert property (rd && spr_sel |=> spr_rdata == $past(seconds_count_word))
        else $error("seconds read");
    rd_frac_a: assert property (rd && !spr_sel |=> spr_rdata == $past(fraction_ns_word))
        else $error("fraction read");
    frac_step_a: assert property (!$past(wf) |-> $stable(fraction_ns_word)
        || fraction_ns_word == $past(fraction_ns_word) + 32'h00000100
        || (fraction_ns_word == 32'h0 && $past(fraction_ns_word) >= rtc_pkg::FRAC_TERMINAL))
        else $error("fraction step");
    sec_count_a: assert property (!$past(ws) && $changed(seconds_count_word)
        |-> seconds_count_word == $past(seconds_count_word) + 32'h00000001
        && fraction_ns_word == 32'h0) else $error("seconds step");
    wrap_carry_a: assert property ($past(fraction_ns_word) != 32'h0
        && fraction_ns_word == 32'h0
        && !$past(spr_valid) |-> seconds_count_word == $past(seconds_count_word) + 32'h00000001)
        else $error("no carry");
    cover property (ws);
    cover property (bad);
    cover property (!$past(ws) && $changed(seconds_count_word));
endmodule : rtc_props

// >>> bench/core_model.sv
// Core model issuing special register moves
`timescale 1ns/1ps
module core_model (
    // Clock
    input wire logic clk,
    // Request
    output logic spr_valid,
    output logic spr_write,
    output logic spr_sel,
    output logic [31:0] spr_wdata,
    output logic spr_privileged,
    // Answer
    input wire logic [31:0] spr_rdata,
    input wire logic spr_done,
    input wire logic program_interrupt
);
    initial begin
        spr_valid = 1'b0;
        spr_write = 1'b0;
        spr_sel = 1'b0;
        spr_wdata = 32'h0;
        spr_privileged = 1'b0;
    end
    task automatic mov(input logic w, s, p, input logic [31:0] d,
                       output logic [31:0] q, output logic ok, irq);
        @(posedge clk);
        #1;
        spr_valid = 1'b1;
        spr_write = w;
        spr_sel = s;
        spr_privileged = p;
        spr_wdata = d;
        @(posedge clk);
        #1;
        ok = spr_done;
        irq = program_interrupt;
        q = spr_rdata;
        spr_valid = 1'b0;
        // Released source bus flips so a stale value never looks valid
        spr_wdata = ~d;
    endtask : mov
    task automatic rd_time(output logic [31:0] s, f, output logic ok);
        logic [31:0] s2;
        logic a, b, c, i;
        repeat (3) begin
            mov(1'b0, 1'b1, 1'b0, 32'h0, s, a, i);
            mov(1'b0, 1'b0, 1'b0, 32'h0, f, b, i);
            mov(1'b0, 1'b1, 1'b0, 32'h0, s2, c, i);
            // Unequal seconds after the last try must not look like a good reading
            ok = a & b & c & (s2 === s);
            if (s2 === s) break;
        end
    endtask : rd_time
endmodule : core_model

// >>> bench/seconds_nanoseconds_time_counter_bench.sv
// Self-checking bench for the two-word time counter
`timescale 1ns/1ps
module seconds_nanoseconds_time_counter_bench;
    logic clk, rst, spr_valid, spr_write, spr_sel, spr_privileged, spr_done, program_interrupt;
    logic [31:0] spr_wdata, spr_rdata, seconds_count_word, fraction_ns_word, q, s, f;
    logic ok, irq;
    int n_mismatch = 0;
    int cmp_count = 0;
    seconds_nanoseconds_time_counter u_seconds_nanoseconds_time_counter (.clk, .rst, .spr_valid,
        .spr_write, .spr_sel, .spr_wdata, .spr_privileged, .spr_rdata, .spr_done,
        .program_interrupt, .seconds_count_word, .fraction_ns_word);
    core_model u_core_model (.clk, .spr_valid, .spr_write, .spr_sel, .spr_wdata,
        .spr_privileged, .spr_rdata, .spr_done, .program_interrupt);
    task automatic chk(input logic c, input string m);
        cmp_count++;
        if (c !== 1'b1) begin
            n_mismatch++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk
    task end_sim;
        if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #(50 * 4000);
        n_mismatch++;
        end_sim;
    end
    initial begin
        rst = 1'b1;
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        chk(seconds_count_word === 32'h0 && fraction_ns_word === 32'h0, "reset");
        u_core_model.mov(1'b1, 1'b0, 1'b1, rtc_pkg::INIT_CLEAR_LOAD, q, ok, irq);
        chk(ok && !irq && fraction_ns_word === 32'h0000FF00, "clear load");
        u_core_model.mov(1'b1, 1'b1, 1'b1, 32'hFFFFFFFF, q, ok, irq);
        u_core_model.mov(1'b1, 1'b0, 1'b1, rtc_pkg::FRAC_TERMINAL - 32'h100, q, ok, irq);
        repeat (12) @(posedge clk);
        u_core_model.rd_time(s, f, ok);
        chk(ok && s === 32'h0 && f < 32'h800, "wrap");
        u_core_model.mov(1'b1, 1'b0, 1'b1, 32'h0, q, ok, irq);
        repeat (100) @(posedge clk);
        u_core_model.mov(1'b0, 1'b0, 1'b0, 32'h0, q, ok, irq);
        chk(ok && q[31:8] >= 24'h000012 && q[31:8] <= 24'h000015 && q[7:0] === 8'h00, "rate");
        u_core_model.mov(1'b1, 1'b1, 1'b0, 32'h12345678, q, ok, irq);
        chk(ok && irq && seconds_count_word === 32'h0, "refused");
        u_core_model.mov(1'b1, 1'b1, 1'b1, 32'hA5A5A5A5, q, ok, irq);
        u_core_model.mov(1'b0, 1'b1, 1'b0, 32'h0, q, ok, irq);
        chk(ok && !irq && q === 32'hA5A5A5A5, "seconds");
        u_core_model.mov(1'b1, 1'b0, 1'b1, 32'hFFFFFFFF, q, ok, irq);
        chk(fraction_ns_word === 32'hFFFFFF00, "over");
        repeat (8) @(posedge clk);
        // Look after the edge so the counters have settled
        #1;
        chk(seconds_count_word === 32'hA5A5A5A6 && fraction_ns_word < 32'h400, "over");
        end_sim;
    end
endmodule : seconds_nanoseconds_time_counter_bench
bind seconds_nanoseconds_time_counter rtc_props u_rtc_props (.clk, .rst, .spr_valid,
    .spr_write, .spr_sel, .spr_wdata, .spr_privileged, .spr_rdata, .spr_done,
    .program_interrupt, .seconds_count_word, .fraction_ns_word);
